// ===== design/sram_host.sv
`timescale 1ns/1ns
`default_nettype none
module sram_host #(
   parameter bit SLOW_GRADE = 1'b0
) (
   input  wire logic                               i_clk,
   input  wire logic                               i_rstn,
   input  wire logic                               i_req,
   input  wire logic                               i_we,
   input  wire logic [sram_host_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [sram_host_pkg::DATA_W-1:0]   i_wdata,
   output logic                                    o_ready,
   output logic                                    o_done,
   output logic      [sram_host_pkg::DATA_W-1:0]   o_rdata,
   output logic      [sram_host_pkg::ADDR_W-1:0]   o_sram_addr,
   output logic                                    o_sram_cs_n,
   output logic                                    o_sram_we_n,
   output logic                                    o_sram_oe_n,
   input  wire logic [sram_host_pkg::DATA_W-1:0]   i_sram_dq,
   output logic      [sram_host_pkg::DATA_W-1:0]   o_sram_dq,
   output logic                                    o_sram_dq_oe
);
   // ************************************************
   // Timing selected by grade
   // ************************************************
   localparam int CNT_W = sram_host_pkg::CNT_W;
   // Read access padded two cycles for the data pin synchroniser
   localparam logic [CNT_W-1:0] N_ACC = sram_host_pkg::cyc_up(SLOW_GRADE ?
      sram_host_pkg::T_ACE_S : sram_host_pkg::T_ACE_F) + CNT_W'(2);
   localparam logic [CNT_W-1:0] N_CHZ = sram_host_pkg::cyc_up(SLOW_GRADE ?
      sram_host_pkg::T_CHZ_S : sram_host_pkg::T_CHZ_F);

   // Pulse covers the longer of strobe width and select-to-end
   localparam int WP_NS = SLOW_GRADE ? sram_host_pkg::T_WP_S : sram_host_pkg::T_WP_F;
   localparam int CW_NS = SLOW_GRADE ? sram_host_pkg::T_CW_S : sram_host_pkg::T_CW_F;
   localparam logic [CNT_W-1:0] N_WR = sram_host_pkg::cyc_up(WP_NS > CW_NS ? WP_NS : CW_NS);
   // Recovery reckoned from select rising, the longer of the two
   localparam logic [CNT_W-1:0] N_REC = sram_host_pkg::cyc_up(sram_host_pkg::T_WR2);
   localparam logic [CNT_W-1:0] N_RC = sram_host_pkg::cyc_up(SLOW_GRADE ?
      sram_host_pkg::T_RC_S : sram_host_pkg::T_RC_F);

   // ************************************************
   // Reset release and data pin sampling
   // ************************************************
   logic [1:0]                         rst_sync;
   logic                               rstn;
   logic [sram_host_pkg::DATA_W-1:0]   dq_meta;
   logic [sram_host_pkg::DATA_W-1:0]   dq_sync;

   // Release ripples through two flops so no register sees a ragged edge
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rstn = rst_sync[1];

   // Data pins belong to no clock; two flops before any logic
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         dq_meta <= 16'h0000;
         dq_sync <= 16'h0000;
      end else begin
         dq_meta <= i_sram_dq;
         dq_sync <= dq_meta;
      end
   end

   // ************************************************
   // Cycle sequencer
   // ************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b011,
      ST_REC   = 3'b100,
      ST_GAP   = 3'b101
   } state_e;

   state_e                             state;
   state_e                             next_state;
   logic [CNT_W-1:0]                   cnt;
   logic [CNT_W-1:0]                   next_cnt;
   logic                               is_write;
   logic                               cnt_zero;
   logic                               take;

   assign cnt_zero = (cnt == 5'h00);
   // Not ready until the internal reset has left, so no request is lost in it
   assign o_ready  = (state == ST_IDLE) && rstn;
   assign take     = o_ready && i_req;

   always_comb begin
      next_state = state;
      // Counter parks at zero rather than wrapping
      next_cnt   = cnt_zero ? cnt : cnt - 5'h01;
      case (state)
         ST_IDLE: begin
            if (i_req) begin
               next_state = ST_SETUP;
               next_cnt   = sram_host_pkg::N_SETTLE;
            end
         end
         // Address settles with both strobes high
         ST_SETUP: begin
            if (cnt_zero) begin
               next_state = is_write ? ST_WRITE : ST_READ;
               next_cnt   = is_write ? N_WR : N_ACC;
            end
         end
         // Select and gate held low for the full access
         ST_READ: begin
            if (cnt_zero) begin
               next_state = ST_GAP;
               next_cnt   = N_CHZ;
            end
         end
         // Pulse covers write pulse, select and address-to-end minimums
         ST_WRITE: begin
            if (cnt_zero) begin
               next_state = ST_REC;
               next_cnt   = N_REC;
            end
         end
         // Data held past the strobes so the word lands cleanly
         ST_REC: begin
            if (cnt_zero) begin
               next_state = ST_GAP;
               next_cnt   = N_RC;
            end
         end
         // Device float time and cycle spacing before next access
         ST_GAP: begin
            if (cnt_zero) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt   = 5'h00;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         cnt   <= 5'h00;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // ************************************************
   // Pin drivers, all registered
   // ************************************************
   logic                               rd_end;
   logic                               wr_end;
   logic                               sel_rd;
   logic                               sel_wr;
   logic                               next_cs_n;
   logic                               next_we_n;
   logic                               next_oe_n;
   logic                               next_dq_oe;

   assign rd_end     = (state == ST_READ) && cnt_zero;
   assign wr_end     = (state == ST_REC) && cnt_zero;
   // Strobe states decoded from the next state so pins move with it
   assign sel_rd     = (next_state == ST_READ);
   assign sel_wr     = (next_state == ST_WRITE);
   // Select and strobe share one edge, so the write spans exactly their overlap
   assign next_cs_n  = !(sel_rd || sel_wr);
   // Strobe stays high on reads
   assign next_we_n  = !sel_wr;
   // Gate off in writes so the device never fights the host
   assign next_oe_n  = !sel_rd;
   // Data driven through the pulse, held in recovery and released after
   assign next_dq_oe = sel_wr || (next_state == ST_REC);

   // Address and data change only while deselected
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         is_write    <= 1'b0;
         o_sram_addr <= 17'h00000;
         o_sram_dq   <= 16'h0000;
      end else if (take) begin
         is_write    <= i_we;
         o_sram_addr <= i_addr;
         o_sram_dq   <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         o_sram_cs_n  <= 1'b1;
         o_sram_we_n  <= 1'b1;
         o_sram_oe_n  <= 1'b1;
         o_sram_dq_oe <= 1'b0;
      end else begin
         o_sram_cs_n  <= next_cs_n;
         o_sram_we_n  <= next_we_n;
         o_sram_oe_n  <= next_oe_n;
         o_sram_dq_oe <= next_dq_oe;
      end
   end

   // Capture after full access time plus sync delay
   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         o_rdata <= 16'h0000;
         o_done  <= 1'b0;
      end else begin
         o_done <= rd_end || wr_end;
         if (rd_end) begin
            o_rdata <= dq_sync;
         end
      end
   end
endmodule : sram_host
`default_nettype wire

// ===== design/sram_host_pkg.sv
// Functional notes
// - A write happens only while chip select and write strobe overlap low.
// - Host holds write strobe high throughout a read cycle.
// - Address is valid no later than chip select falling in a read.
// - Chip select low at least 75 or 100 ns before write end.
// - Address valid at least 75 or 100 ns before write end.
// - Active write lasts at least 65 or 85 ns.
// - Recovery of 5 ns after strobe or 15 ns after chip select.
// - Write data valid at least 35 or 45 ns before write end.
`default_nettype none
package sram_host_pkg;
   localparam int ADDR_W   = 17;
   localparam int DATA_W   = 16;
   localparam int CLK_NS   = 10;
   localparam int CNT_W    = 5;
   // Times in ns, fast grade then slow grade
   localparam int T_RC_F   = 85;
   localparam int T_RC_S   = 120;
   localparam int T_ACE_F  = 85;
   localparam int T_ACE_S  = 120;
   localparam int T_CHZ_F  = 35;
   localparam int T_CHZ_S  = 45;
   localparam int T_WP_F   = 65;
   localparam int T_WP_S   = 85;
   localparam int T_CW_F   = 75;
   localparam int T_CW_S   = 100;
   localparam int T_WR2    = 15;
   // Least times round up; the host adds two cycles of input sampling margin on reads
   function automatic logic [CNT_W-1:0] cyc_up(input int ns);
      cyc_up = CNT_W'((ns + CLK_NS - 1) / CLK_NS);
   endfunction : cyc_up
   localparam logic [CNT_W-1:0] N_SETTLE = 5'h01;
endpackage : sram_host_pkg
`default_nettype wire

// ===== verif/sram_host_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sram_host_checker (
   input wire logic                             i_clk,
   input wire logic                             i_rstn,
   input wire logic                             i_req,
   input wire logic                             o_ready,
   input wire logic                             o_done,
   input wire logic [sram_host_pkg::ADDR_W-1:0] o_sram_addr,
   input wire logic                             o_sram_cs_n,
   input wire logic                             o_sram_we_n,
   input wire logic                             o_sram_oe_n,
   input wire logic [sram_host_pkg::DATA_W-1:0] o_sram_dq,
   input wire logic                             o_sram_dq_oe
);
   // ****
   // Fast grade, figures in 10 ns cycles
   // ****
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_read_we_high: assert property (!o_sram_oe_n |-> o_sram_we_n)
      else $error("strobe low in read");
   a_cs_hold: assert property ($fell(o_sram_cs_n) |-> !o_sram_cs_n [*8])
      else $error("select too short");
   a_we_pulse: assert property ($fell(o_sram_we_n) |-> !o_sram_we_n [*7])
      else $error("write pulse too short");
   a_wr_overlap: assert property (!o_sram_we_n |-> !o_sram_cs_n && o_sram_dq_oe)
      else $error("strobe outside select");
   a_addr_held: assert property (!o_sram_cs_n |-> $stable(o_sram_addr))
      else $error("address moved");
   a_data_held: assert property (!o_sram_we_n |-> $stable(o_sram_dq))
      else $error("write data moved");
   a_no_fight: assert property (o_sram_dq_oe |-> o_sram_oe_n)
      else $error("both sides drive");
   a_done_once: assert property (o_ready && i_req |-> ##15 o_done ##1 !o_done)
      else $error("done late or long");
   a_gap_kept: assert property (o_done |=> !o_ready [*3])
      else $error("gap too short");
   c_read: cover property (!o_sram_oe_n ##[1:20] o_done);
   c_write: cover property (!o_sram_we_n ##[1:20] o_done);
   c_refused: cover property (!o_ready && i_req);
endmodule : sram_host_checker
bind sram_host sram_host_checker u_chk (.i_clk, .i_rstn, .i_req, .o_ready, .o_done, .o_sram_addr,
   .o_sram_cs_n, .o_sram_we_n, .o_sram_oe_n, .o_sram_dq, .o_sram_dq_oe);
`default_nettype wire

// ===== verif/sram_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module sram_dev_model #(
   parameter int ACC_NS = 80
) (
   input  wire logic [16:0] i_addr,
   input  wire logic        i_cs_n,
   input  wire logic        i_we_n,
   input  wire logic        i_oe_n,
   input  wire logic [15:0] i_dq,
   output logic      [15:0] o_dq
);
   // ****
   // Memory array and output gating
   // ****
   logic [15:0] mem [logic [16:0]];
   logic [15:0] last = 16'h0000;
   logic        shown = 1'b0;
   logic        armed = 1'b0;
   wire         wr_n = i_cs_n | i_we_n;
   wire         rd = !i_cs_n && i_we_n && !i_oe_n;
   always @(negedge wr_n) armed = 1'b1;
   always @(posedge wr_n) begin
      if (armed) mem[i_addr] = i_dq;
      armed = 1'b0;
   end
   always @(rd) shown <= #(rd ? ACC_NS : 20) rd;
   // Word fetched as the output turns on, kept until the next read is valid
   always @(posedge shown) last = mem.exists(i_addr) ? mem[i_addr] : 16'h0000;
   // No pull on the bus: a released line shows the inverse, never the old word
   assign o_dq = shown ? last : ~last;
endmodule : sram_dev_model
`default_nettype wire

// ===== verif/sram_host_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define check(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module sram_host_tb;
   // ****
   // Bench, dut and device model
   // ****
   logic        i_clk = 1'b0, i_rstn = 1'b0, i_req = 1'b0, i_we = 1'b0;
   logic [16:0] i_addr = 17'h00000;
   logic [15:0] i_wdata = 16'h0000, seed = 16'h004a;
   logic        o_ready, o_done, o_sram_cs_n, o_sram_we_n, o_sram_oe_n, o_sram_dq_oe;
   logic [15:0] o_rdata, o_sram_dq, dev_dq;
   logic [16:0] o_sram_addr;
   wire  [15:0] i_sram_dq = o_sram_dq_oe ? o_sram_dq : dev_dq;
   logic [15:0] ref_mem [logic [16:0]];
   int          error_cnt = 0, check_count = 0, cycles = 0;
   always #5 i_clk = ~i_clk;
   sram_host #(.SLOW_GRADE(1'b0)) dut (.i_clk, .i_rstn, .i_req, .i_we, .i_addr, .i_wdata,
      .o_ready, .o_done, .o_rdata, .o_sram_addr, .o_sram_cs_n, .o_sram_we_n, .o_sram_oe_n,
      .i_sram_dq, .o_sram_dq, .o_sram_dq_oe);
   sram_dev_model #(.ACC_NS(80)) u_dev (.i_addr(o_sram_addr), .i_cs_n(o_sram_cs_n),
      .i_we_n(o_sram_we_n), .i_oe_n(o_sram_oe_n), .i_dq(i_sram_dq), .o_dq(dev_dq));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [15:0] expect_rd(input logic [16:0] a);
      expect_rd = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
   endfunction : expect_rd
   function automatic int cyc(input int ns);
      cyc = (ns + sram_host_pkg::CLK_NS - 1) / sram_host_pkg::CLK_NS;
   endfunction : cyc
   // Negedges from take to done: settle, strobe phase, recovery, sampling
   function automatic int exp_n(input logic w);
      exp_n = 3 + sram_host_pkg::N_SETTLE + (w ? cyc(sram_host_pkg::T_CW_F) +
              cyc(sram_host_pkg::T_WR2) + 1 : cyc(sram_host_pkg::T_ACE_F) + 2);
   endfunction : exp_n
   task automatic results;
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   task automatic access(input logic w, input logic [16:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge i_clk);
      while (o_ready !== 1'b1) @(negedge i_clk);
      @(posedge i_clk);
      {i_req, i_we, i_addr, i_wdata} <= {1'b1, w, a, d};
      @(posedge i_clk);
      // Request stays up as a write of other data while busy
      {i_we, i_wdata} <= {1'b1, ~d};
      do begin
         @(negedge i_clk);
         n++;
      end while (o_done !== 1'b1 && n < 30);
      `check(n, exp_n(w))
      if (!w) `check(o_rdata, expect_rd(a))
      else ref_mem[a] = d;
      @(posedge i_clk);
      i_req <= 1'b0;
   endtask : access
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      logic [16:0] a;
      logic        w;
      repeat (10) @(posedge i_clk);
      i_rstn <= 1'b1;
      access(1'b1, 17'h00000, 16'hffff);
      access(1'b1, 17'h1ffff, 16'h0000);
      access(1'b0, 17'h00000, 16'h0000);
      access(1'b0, 17'h1ffff, 16'h0000);
      access(1'b0, 17'h00005, 16'h0000);
      for (int k = 0; k < 30; k++) begin
         seed = lfsr(seed);
         a = {seed[15], 12'h000, seed[3:0]};
         w = seed[8];
         seed = lfsr(seed);
         access(w, a, seed);
      end
      results();
   end
endmodule : sram_host_tb
`default_nettype wire
